// ==== sgcr_regs.sv ====
// sgcr_regs.sv: global control registers for port 5 mii, storm limit, power save
// assumes strap pins are asynchronous and held stable around reset release
`timescale 1ns/10ps
`include "sgcr_params.svh"

module sgcr_regs #(
  parameter int WIN_FAST_CYC = `SGCR_WIN_FAST_MS * `SGCR_CLK_KHZ,
  parameter int WIN_SLOW_CYC = `SGCR_WIN_SLOW_MS * `SGCR_CLK_KHZ
) (
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  // strap pins
  input  wire logic              flow_ctrl_strap_pin_in,
  input  wire logic              speed_strap_pin_in,
  // register port
  input  wire sgcr_pkg::sgcr_req_t req_in,
  output logic [7:0]             rdata_out,
  output logic                   rvalid_out,
  // settings and window
  output sgcr_pkg::sgcr_cfg_t    cfg_out,
  output logic                   window_tick_out
);
  import sgcr_pkg::*;

  logic [1:0]  strap_s1_reg, strap_s2_reg;
  logic        strap_done_reg, strap_done_next;
  logic [1:0]  strap_cnt_reg, strap_cnt_next;
  logic        flow_reg, flow_next, speed_reg, speed_next, nvid_reg, nvid_next;
  logic        pwr_reg, pwr_next;
  logic [2:0]  hi_reg, hi_next;
  logic [7:0]  lo_reg, lo_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] win_cnt_reg, win_cnt_next;
  logic        tick_reg, tick_next;

  // read mux decode
  function automatic logic [7:0] read_value(input logic [7:0] a, input logic f,
      input logic s, input logic n, input logic [2:0] h, input logic [7:0] l,
      input logic p);
    logic [7:0] v;
    v = 8'h00;
    if (a == `SGCR_ADDR_CTRL4) begin
      v = {2'h0, f, s, n, h};
    end else if (a == `SGCR_ADDR_STORM_LO) begin
      v = l;
    end else if (a == `SGCR_ADDR_TEST_A) begin
      v = `SGCR_RST_TEST_A;
    end else if (a == `SGCR_ADDR_TEST_B) begin
      v = `SGCR_RST_TEST_B;
    end else if (a == `SGCR_ADDR_TEST_C) begin
      v = `SGCR_RST_TEST_C;
    end else if (a == `SGCR_ADDR_PWR) begin
      v = {4'h0, p, 3'h0};
    end
    return v;
  endfunction : read_value

  // strap synchroniser, two stages, plus the strap load counter
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      strap_s1_reg   <= 2'h0;
      strap_s2_reg   <= 2'h0;
      strap_cnt_reg  <= 2'h0;
      strap_done_reg <= 1'b0;
    end else begin
      strap_s1_reg   <= {flow_ctrl_strap_pin_in, speed_strap_pin_in};
      strap_s2_reg   <= strap_s1_reg;
      strap_cnt_reg  <= strap_cnt_next;
      strap_done_reg <= strap_done_next;
    end
  end

  // strap load window: the second stage holds the pin level only from the second
  // edge after release, so the settings copy it for three edges before writes open
  always_comb begin
    strap_cnt_next  = strap_cnt_reg;
    strap_done_next = strap_done_reg;
    if (!strap_done_reg) begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == `SGCR_STRAP_LOAD_LAST) begin
        strap_done_next = 1'b1;
      end
    end
  end

  // register next values; strap loads once after reset release
  always_comb begin
    flow_next  = flow_reg;
    speed_next = speed_reg;
    nvid_next  = nvid_reg;
    hi_next    = hi_reg;
    lo_next    = lo_reg;
    pwr_next   = pwr_reg;
    if (!strap_done_reg) begin
      flow_next  = strap_s2_reg[1];
      speed_next = strap_s2_reg[0];
    end else if (req_in.wr) begin
      if (req_in.addr == `SGCR_ADDR_CTRL4) begin
        flow_next  = req_in.wdata[`SGCR_BIT_FLOW];
        speed_next = req_in.wdata[`SGCR_BIT_SPEED];
        nvid_next  = req_in.wdata[`SGCR_BIT_NULLVID];
        hi_next    = req_in.wdata[2:0];
      end else if (req_in.addr == `SGCR_ADDR_STORM_LO) begin
        lo_next = req_in.wdata;
      end else if (req_in.addr == `SGCR_ADDR_PWR) begin
        pwr_next = req_in.wdata[`SGCR_BIT_PWR];
      end
    end
    rdata_next = read_value(req_in.addr, flow_reg, speed_reg, nvid_reg, hi_reg,
                            lo_reg, pwr_reg);
    rvalid_next = req_in.rd;
  end

  // register storage
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      flow_reg       <= 1'b0;
      speed_reg      <= 1'b0;
      nvid_reg       <= 1'b0;
      hi_reg         <= `SGCR_RST_STORM_HI;
      lo_reg         <= `SGCR_RST_STORM_LO;
      pwr_reg        <= 1'b0;
      rdata_reg      <= 8'h00;
      rvalid_reg     <= 1'b0;
    end else begin
      flow_reg       <= flow_next;
      speed_reg      <= speed_next;
      nvid_reg       <= nvid_next;
      hi_reg         <= hi_next;
      lo_reg         <= lo_next;
      pwr_reg        <= pwr_next;
      rdata_reg      <= rdata_next;
      rvalid_reg     <= rvalid_next;
    end
  end

  // storm measurement window, length chosen by link rate
  always_comb begin
    win_cnt_next = win_cnt_reg + 32'h1;
    tick_next    = 1'b0;
    if (win_cnt_reg >= (speed_reg ? 32'(WIN_SLOW_CYC - 1) : 32'(WIN_FAST_CYC - 1))) begin
      win_cnt_next = 32'h0;
      tick_next    = 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      win_cnt_reg <= 32'h0;
      tick_reg    <= 1'b0;
    end else begin
      win_cnt_reg <= win_cnt_next;
      tick_reg    <= tick_next;
    end
  end

  // outputs, all from flip-flops
  assign rdata_out       = rdata_reg;
  assign rvalid_out      = rvalid_reg;
  assign window_tick_out = tick_reg;
  assign cfg_out.flow_ctrl_en      = flow_reg;
  assign cfg_out.slow_link_rate    = speed_reg;
  assign cfg_out.null_vid_replace  = nvid_reg;
  assign cfg_out.phy_psave_disable = pwr_reg;
  assign cfg_out.storm_limit       = {hi_reg, lo_reg};

  // storm limit write lands next cycle
  a_storm_lo_write: assert property (@(posedge clock_in) disable iff (rst_in)
    strap_done_reg && req_in.wr && req_in.addr == `SGCR_ADDR_STORM_LO
    |=> cfg_out.storm_limit[7:0] == $past(req_in.wdata))
    else $error("storm low byte not stored");

  // test register b reads fixed, whether written or not
  a_test_fixed: assert property (@(posedge clock_in) disable iff (rst_in)
    req_in.addr == `SGCR_ADDR_TEST_B |=> rdata_out == `SGCR_RST_TEST_B)
    else $error("test register b not fixed");

  // power save readback keeps reserved bits clear
  a_pwr_readback: assert property (@(posedge clock_in) disable iff (rst_in)
    req_in.addr == `SGCR_ADDR_PWR
    |=> rdata_out == {4'h0, $past(cfg_out.phy_psave_disable), 3'h0})
    else $error("power save readback wrong");

  // window tick rises on the same edge that the counter wraps to zero
  a_window_wrap: assert property (@(posedge clock_in) disable iff (rst_in)
    tick_reg |-> win_cnt_reg == 32'h0)
    else $error("window wrap misaligned");

  // ctrl4 write updates the flags
  a_ctrl4_write: assert property (@(posedge clock_in) disable iff (rst_in)
    strap_done_reg && req_in.wr && req_in.addr == `SGCR_ADDR_CTRL4
    |=> cfg_out.null_vid_replace == $past(req_in.wdata[`SGCR_BIT_NULLVID])
        && cfg_out.slow_link_rate == $past(req_in.wdata[`SGCR_BIT_SPEED])
        && cfg_out.flow_ctrl_en == $past(req_in.wdata[`SGCR_BIT_FLOW]))
    else $error("ctrl4 flags not stored");

  // flow control setting follows its strap once loading ends
  a_strap_flow: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(strap_done_reg) |-> cfg_out.flow_ctrl_en == $past(strap_s2_reg[1]))
    else $error("flow control strap not loaded");

  // link rate setting follows its strap once loading ends
  a_strap_speed: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(strap_done_reg) |-> cfg_out.slow_link_rate == $past(strap_s2_reg[0]))
    else $error("link rate strap not loaded");

  // writes to the factory test offsets leave every setting untouched
  a_test_write_ignored: assert property (@(posedge clock_in) disable iff (rst_in)
    strap_done_reg && req_in.wr && req_in.addr >= `SGCR_ADDR_TEST_A
    && req_in.addr <= `SGCR_ADDR_TEST_C |=> $stable(cfg_out))
    else $error("factory test write changed a setting");

  // the window pulse lasts a single cycle
  a_tick_single: assert property (@(posedge clock_in) disable iff (rst_in)
    tick_reg |=> !tick_reg)
    else $error("window pulse longer than one cycle");

endmodule : sgcr_regs

// ==== sgcr_params.svh ====
// sgcr_params.svh: offsets, field positions, reset values and timing counts
// assumes a byte-wide register port with 8-bit addresses
`ifndef SGCR_PARAMS_SVH
`define SGCR_PARAMS_SVH

// register offsets
`define SGCR_ADDR_CTRL4      8'h06
`define SGCR_ADDR_STORM_LO   8'h07
`define SGCR_ADDR_TEST_A     8'h08
`define SGCR_ADDR_TEST_B     8'h09
`define SGCR_ADDR_TEST_C     8'h0A
`define SGCR_ADDR_PWR        8'h0B

// field positions of the port-5 control register and the power save register
`define SGCR_BIT_FLOW        5
`define SGCR_BIT_SPEED       4
`define SGCR_BIT_NULLVID     3
`define SGCR_BIT_PWR         3

// reset values
`define SGCR_RST_STORM_HI    3'h0
`define SGCR_RST_STORM_LO    8'h4A
`define SGCR_RST_TEST_A      8'h24
`define SGCR_RST_TEST_B      8'h28
`define SGCR_RST_TEST_C      8'h00

// strap load: last counter value before register writes are accepted
`define SGCR_STRAP_LOAD_LAST 2'h2

// storm window lengths
`define SGCR_WIN_FAST_MS     50
`define SGCR_WIN_SLOW_MS     500
`define SGCR_CLK_KHZ         25000

`endif

// ==== sgcr_pkg.sv ====
// sgcr_pkg.sv: types shared by the global control register bank
// assumes sgcr_params.svh supplies the numeric constants
package sgcr_pkg;

  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sgcr_req_t;

  // control settings that steer the switch core
  typedef struct packed {
    logic        flow_ctrl_en;
    logic        slow_link_rate;
    logic        null_vid_replace;
    logic        phy_psave_disable;
    logic [10:0] storm_limit;
  } sgcr_cfg_t;

endpackage : sgcr_pkg

// ==== sgcr_regs_tb.sv ====
// sgcr_regs_tb.sv: self-checking bench for the global control register bank
// assumes one-cycle register port pulses and shortened storm window counts
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, b); end end

module sgcr_regs_tb;
  import sgcr_pkg::*;
  localparam int FAST = 10;
  localparam int SLOW = 100;
  logic        clock_in;
  logic        rst_in;
  logic        flow_strap;
  logic        speed_strap;
  sgcr_req_t   req;
  logic [7:0]  rdata;
  logic        rvalid;
  sgcr_cfg_t   cfg;
  logic        tick;
  int          mismatches;
  int          total_checks;
  int          n;
  logic [7:0]  ad;
  // behavioural copy of the writable state
  logic [5:0]  c4_m;
  logic [7:0]  lo_m;
  logic        pwr_m;

  sgcr_regs #(.WIN_FAST_CYC(FAST), .WIN_SLOW_CYC(SLOW)) u_sgcr_regs (
    .clock_in(clock_in), .rst_in(rst_in), .flow_ctrl_strap_pin_in(flow_strap),
    .speed_strap_pin_in(speed_strap), .req_in(req), .rdata_out(rdata),
    .rvalid_out(rvalid), .cfg_out(cfg), .window_tick_out(tick));

  // 25 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // expected read value of each offset
  function automatic logic [7:0] rd_exp(input logic [7:0] a);
    case (a)
      8'h06: return {2'h0, c4_m};
      8'h07: return lo_m;
      8'h08: return 8'h24;
      8'h09: return 8'h28;
      8'h0B: return {4'h0, pwr_m, 3'h0};
      default: return 8'h00;
    endcase
  endfunction : rd_exp

  function automatic sgcr_cfg_t cfg_exp();
    return {c4_m[5], c4_m[4], c4_m[3], pwr_m, c4_m[2:0], lo_m};
  endfunction : cfg_exp

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // one write pulse, then the settings must follow the model
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_in);
    #1 req.wr = 1'b0;
    case (a)
      8'h06: c4_m = d[5:0];
      8'h07: lo_m = d;
      8'h0B: pwr_m = d[3];
      default: ;
    endcase
    `CHK(cfg, cfg_exp())
  endtask : wr

  // one read pulse, answer one cycle later
  task automatic rd(input logic [7:0] a);
    @(posedge clock_in);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_in);
    #1 req.rd = 1'b0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, rd_exp(a))
  endtask : rd

  // cycles until the next window pulse, bounded
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge clock_in);
      #1 c++;
    end while (tick !== 1'b1 && c < 400);
    if (tick !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
  endtask : wait_tick

  // main sequence
  initial begin
    rst_in = 1'b1;
    req = '0;
    mismatches = 0;
    total_checks = 0;
    void'($urandom(82195));
    {flow_strap, speed_strap} = 2'($urandom());
    c4_m = {flow_strap, speed_strap, 4'h0};
    lo_m = 8'h4A;
    pwr_m = 1'b0;
    repeat (12) @(posedge clock_in);
    #1 rst_in = 1'b0;
    repeat (6) @(posedge clock_in);
    #1 `CHK(cfg, cfg_exp())
    for (int a = 6; a < 12; a++) rd(8'(a));
    $display("reset values done");
    // random writes over mapped, read-only and unmapped offsets
    repeat (40) begin
      ad = 8'h06 + 8'($urandom_range(6));
      wr(ad, 8'($urandom()));
      if (ad != 8'h0C) rd(ad);
    end
    $display("random writes done");
    // storm window length at each link rate
    wr(8'h06, 8'h00);
    repeat (3) wait_tick(n);
    `CHK(n, FAST)
    wr(8'h06, 8'h10);
    repeat (3) wait_tick(n);
    `CHK(n, SLOW)
    $display("storm window done");
    // second reset in mid-run with the straps turned over
    @(posedge clock_in);
    #1 rst_in = 1'b1;
    {flow_strap, speed_strap} = ~{flow_strap, speed_strap};
    c4_m = {flow_strap, speed_strap, 4'h0};
    lo_m = 8'h4A;
    pwr_m = 1'b0;
    repeat (2) @(posedge clock_in);
    #1 rst_in = 1'b0;
    repeat (6) @(posedge clock_in);
    #1 `CHK(cfg, cfg_exp())
    rd(8'h06);
    $display("second reset done");
    report_and_stop();
  end
endmodule : sgcr_regs_tb
